// File: logic/tuner_regs_pkg.sv
// Package: offsets, field layout and reset values of the tuner id and
// power configuration register front end.
// Assumes a plain address/strobe register port on one 100 MHz clock.
package tuner_regs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] DEVICE_IDENTIFICATION_OFS = 4'h0;
  localparam logic [3:0] CHIP_VERSION_INFO_OFS = 4'h1;
  localparam logic [3:0] POWER_CONFIGURATION_OFS = 4'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SOFT_ATTENUATION_OFF_BIT = 15;
  localparam int HARD_SILENCE_OFF_BIT = 14;
  localparam int FORCE_MONO_BIT = 13;
  localparam int PWR_RESERVED_BIT = 12;
  localparam int POWERDOWN_REQ_BIT = 6;
  localparam int POWERUP_REQ_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] POWER_CONFIGURATION_RST = 16'h0000;
  localparam logic [15:0] READ_DATA_RST = 16'h0000;
  localparam logic [5:0] FIRMWARE_OFF_VALUE = 6'h00;

  // Upper power configuration bits held by this block
  typedef struct packed {
    logic soft_attenuation_off;
    logic hard_silence_off;
    logic force_mono;
  } audio_ctrl_t;

  // Chip-version word layout
  typedef struct packed {
    logic [5:0] version;
    logic [3:0] part_variant_code;
    logic [5:0] firmware;
  } chip_version_t;

endpackage : tuner_regs_pkg

// File: logic/power_state_track.sv
// Powered-up state tracker: follows the powerup and powerdown request
// bits of the power configuration word.
// Assumes the request bits come from registers on the same clock.
`timescale 1ns/1ns
module power_state_track
  import tuner_regs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic powerup_req_i,
  input wire logic powerdown_req_i,
  output logic powered_o
);

  logic next_powered;

  always_comb begin
    next_powered = powered_o;
    if (powerup_req_i && !powerdown_req_i) begin
      next_powered = 1'b1;
    end else if (powerup_req_i && powerdown_req_i) begin
      next_powered = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      powered_o <= 1'b0;
    end else begin
      powered_o <= next_powered;
    end
  end

endmodule // power_state_track

// File: logic/tuner_id_power_regs.sv
// Identification and power configuration registers of the tuner.
// Assumes a host master on the plain register port, same clock.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module tuner_id_power_regs
  import tuner_regs_pkg::*;
#(
  // Arbitrary identity values, not tied to any real part
  parameter logic [3:0] PART_NUMBER_FIELD = 4'h5,
  parameter logic [11:0] MAKER_CODE_FIELD = 12'hABC,
  parameter logic [5:0] CHIP_VERSION = 6'h2A,
  parameter logic [3:0] VARIANT_OFF = 4'h6,
  parameter logic [3:0] VARIANT_ON = 4'h7,
  parameter logic [5:0] FIRMWARE_ON = 6'h15
)(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic soft_attenuation_off_o,
  output logic hard_silence_off_o,
  output logic force_mono_o,
  output logic powered_o
);

  // ----------------------------------------------------------------
  // Power configuration word
  // ----------------------------------------------------------------
  logic [15:0] power_configuration;
  logic [15:0] next_power_configuration;
  logic [15:0] next_rdata;
  audio_ctrl_t audio;
  audio_ctrl_t next_audio;
  logic powered;
  chip_version_t chip;

  // Write strobe aimed at the power configuration word
  function automatic logic cfg_write(input logic wr, input logic [3:0] addr);
    return wr && addr == POWER_CONFIGURATION_OFS;
  endfunction

  always_comb begin
    next_power_configuration = power_configuration;
    // Only the config offset takes writes; id words drop them
    if (cfg_write(wr_i, addr_i)) begin
      next_power_configuration = wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      power_configuration <= POWER_CONFIGURATION_RST;
    end else begin
      power_configuration <= next_power_configuration;
    end
  end

  // ----------------------------------------------------------------
  // Audio controls, registered from the next word, in step with the store
  // ----------------------------------------------------------------
  always_comb begin
    next_audio.soft_attenuation_off =
      next_power_configuration[SOFT_ATTENUATION_OFF_BIT];
    next_audio.hard_silence_off =
      next_power_configuration[HARD_SILENCE_OFF_BIT];
    next_audio.force_mono =
      next_power_configuration[FORCE_MONO_BIT];
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      audio <= '0;
    end else begin
      audio <= next_audio;
    end
  end

  assign soft_attenuation_off_o = audio.soft_attenuation_off;
  assign hard_silence_off_o = audio.hard_silence_off;
  assign force_mono_o = audio.force_mono;

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Tracker looks at the stored word, so it lags the write by two cycles, one behind the audio controls
  power_state_track u_power (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .powerup_req_i(power_configuration[POWERUP_REQ_BIT]),
    .powerdown_req_i(power_configuration[POWERDOWN_REQ_BIT]),
    .powered_o(powered)
  );

  assign powered_o = powered;

  always_comb begin
    chip.version = CHIP_VERSION;
    chip.part_variant_code = powered ? VARIANT_ON : VARIANT_OFF;
    chip.firmware = powered ? FIRMWARE_ON : FIRMWARE_OFF_VALUE;
  end

  // ----------------------------------------------------------------
  // Read port: data in the cycle after the strobe only
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = READ_DATA_RST;
    if (rd_i) begin
      unique case (addr_i)
        DEVICE_IDENTIFICATION_OFS:
          next_rdata = {PART_NUMBER_FIELD, MAKER_CODE_FIELD};
        CHIP_VERSION_INFO_OFS: next_rdata = chip;
        POWER_CONFIGURATION_OFS:
          next_rdata = power_configuration;
        default: next_rdata = READ_DATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      rdata_o <= READ_DATA_RST;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ID_CONST: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i == DEVICE_IDENTIFICATION_OFS |=>
      rdata_o == {PART_NUMBER_FIELD, MAKER_CODE_FIELD})
    else $error("id word wrong");
  AST_FW_ZERO: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i == CHIP_VERSION_INFO_OFS && !powered |=>
      rdata_o[5:0] == FIRMWARE_OFF_VALUE)
    else $error("firmware not zero before powerup");
  AST_SOFT: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_write(wr_i, addr_i) |=>
      soft_attenuation_off_o == $past(wdata_i[SOFT_ATTENUATION_OFF_BIT]))
    else $error("soft attenuation control wrong");
  AST_MUTE: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_write(wr_i, addr_i) |=>
      hard_silence_off_o == $past(wdata_i[HARD_SILENCE_OFF_BIT]))
    else $error("mute control wrong");
  AST_MONO: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_write(wr_i, addr_i) |=>
      force_mono_o == $past(wdata_i[FORCE_MONO_BIT]))
    else $error("mono control wrong");
  AST_POWERUP: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_write(wr_i, addr_i) && wdata_i[POWERUP_REQ_BIT] &&
      !wdata_i[POWERDOWN_REQ_BIT] |=> ##1 powered_o)
    else $error("powerup not seen");
  AST_READBACK: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_write(wr_i, addr_i) ##1
      rd_i && addr_i == POWER_CONFIGURATION_OFS && !wr_i
      |=> rdata_o == $past(wdata_i, 2))
    else $error("config readback wrong");
  AST_ID_NOWRITE: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    wr_i && addr_i != POWER_CONFIGURATION_OFS
      |=> $stable(power_configuration))
    else $error("write to read-only word took effect");

  // ----------------------------------------------------------------
  // Read port and state checks
  // ----------------------------------------------------------------
  // Idle read data stay zero, so a stale word never poses as an answer
  AST_RDATA_IDLE: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !rd_i |=>
      rdata_o == READ_DATA_RST)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i > POWER_CONFIGURATION_OFS |=>
      rdata_o == READ_DATA_RST)
    else $error("unmapped read not zero");
  AST_VERSION: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i == CHIP_VERSION_INFO_OFS |=>
      rdata_o[15:10] == CHIP_VERSION)
    else $error("chip version field wrong");
  AST_FW_POWERED: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && addr_i == CHIP_VERSION_INFO_OFS && powered |=>
      rdata_o[5:0] == FIRMWARE_ON)
    else $error("firmware field wrong after powerup");
  AST_RD_NOWRITE: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_i && !wr_i |=>
      $stable(power_configuration))
    else $error("read disturbed the config word");
  AST_AUDIO_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !cfg_write(wr_i, addr_i) |=> $stable({soft_attenuation_off_o,
      hard_silence_off_o, force_mono_o}))
    else $error("audio controls moved without a write");
  // Tracker is idempotent, so an unchanged word must leave the state alone
  AST_POWER_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    $stable(power_configuration) |=>
      $stable(powered_o))
    else $error("powered state moved without a request");
  AST_POWERDOWN: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    cfg_write(wr_i, addr_i) && wdata_i[POWERUP_REQ_BIT] &&
      wdata_i[POWERDOWN_REQ_BIT] |=> ##1 !powered_o)
    else $error("powerdown not seen");
  AST_RESET_AUDIO: assert property (
    @(posedge ref_clk_i)
    !nrst_i |=> !soft_attenuation_off_o && !hard_silence_off_o &&
      !force_mono_o)
    else $error("audio controls not at default after reset");
  AST_RESET_STATE: assert property (
    @(posedge ref_clk_i)
    !nrst_i |=> !powered_o && rdata_o == READ_DATA_RST &&
      power_configuration == POWER_CONFIGURATION_RST)
    else $error("state not cleared by reset");

endmodule // tuner_id_power_regs

// File: testbench/host_model.sv
// Host controller model on the plain register port of the tuner.
// Assumes one clock; the bench calls its tasks hierarchically.
`timescale 1ns/1ns
module host_model (
  input wire logic ref_clk_i,
  input wire logic [15:0] rdata_i,
  output logic [3:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  initial begin
    addr_o = 4'hF;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d & 16'hEFFF;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    // Released lines show garbage, never the last value
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] q);
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    q = rdata_i;
  endtask
  // Write then read of one word with no idle cycle between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d & 16'hEFFF;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b1;
    wdata_o <= ~d;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    q = rdata_i;
  endtask
  // Powerup: request set while powerdown request stays clear
  task automatic power_up();
    wr_reg(4'h2, 16'h0001);
  endtask
endmodule // host_model

// File: testbench/test_tuner_id_power_regs.sv
// Self-checking bench for the tuner id and power configuration block.
// Assumes the design defaults for its arbitrary identity parameters.
`timescale 1ns/1ns
module test_tuner_id_power_regs;
  import tuner_regs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, q, w;
  logic wr, rd, sa_off, hs_off, mono, pwr;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 32'hf1af;
  always #5 ref_clk_i = ~ref_clk_i;
  host_model h (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  tuner_id_power_regs dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .soft_attenuation_off_o(sa_off),
    .hard_silence_off_o(hs_off), .force_mono_o(mono), .powered_o(pwr));
  // ---------------------------------------------------------------
  // Expectations and checks
  // ---------------------------------------------------------------
  function automatic logic [15:0] chip_word(input logic on);
    return {6'h2A, on ? 4'h7 : 4'h6, on ? 6'h15 : FIRMWARE_OFF_VALUE};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
    h.rd_reg(a, q);
    check(q, exp);
  endtask
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd_check(4'h0, 16'h5ABC);
    rd_check(4'h1, chip_word(1'b0));
    rd_check(4'h2, POWER_CONFIGURATION_RST);
    check({13'h0, sa_off, hs_off, mono}, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      w = 16'($random(seed));
      w[6] = 1'b0;
      w[0] = 1'b0;
      h.wr_reg(4'h2, w);
      w[12] = 1'b0;
      check({13'h0, sa_off, hs_off, mono}, {13'h0, w[15:13]});
      h.wr_reg(4'(i % 2), 16'($random(seed)));
      h.wr_reg(4'(3 + i % 13), 16'($random(seed)));
      rd_check(4'h2, w);
      rd_check(4'(i % 2), i % 2 ? chip_word(1'b0) : 16'h5ABC);
      rd_check(4'(3 + i % 13), 16'h0000);
      // Back-to-back strobes; bits 12, 6 and 0 kept clear
      w = 16'($random(seed)) & 16'hEFBE;
      h.wr_rd(4'h2, w, q);
      check(q, w);
      @(posedge ref_clk_i);
      #1;
      check(rdata, 16'h0000);
    end
    h.power_up();
    @(posedge ref_clk_i);
    #1;
    check({15'h0, pwr}, 16'h0001);
    rd_check(4'h1, chip_word(1'b1));
    rd_check(4'h0, 16'h5ABC);
    h.wr_reg(4'h2, 16'hE041);
    @(posedge ref_clk_i);
    #1;
    check({12'h0, sa_off, hs_off, mono, pwr}, 16'h000E);
    rd_check(4'h1, chip_word(1'b0));
    h.power_up();
    @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1;
    check({12'h0, sa_off, hs_off, mono, pwr}, 16'h0000);
    rd_check(4'h2, POWER_CONFIGURATION_RST);
    finish_test();
  end
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    bad_count++;
    finish_test();
  end
endmodule // test_tuner_id_power_regs
